// File: core/tlc_cfg.svh
// Constants for the two-level cache controller
`ifndef TLC_CFG_SVH
`define TLC_CFG_SVH
// Processor data word width in bits
`define TLC_WORD_W 32
// Processor word address width in bits
`define TLC_ADDR_W 30
// Bytes in one word
`define TLC_WORD_BYTES 4
// Level-1 capacity in bytes
`define TLC_L1_BYTES 16384
// Level-2 capacity in bytes
`define TLC_L2_BYTES 262144
// Write policy after reset: 0 is write-back
`define TLC_POLICY_RESET 1'h0
`endif

// File: core/tlc_ctrl.sv
// Two-level cache controller for one processor core
// Summary of operation
// RULE1: Level-1 hits answered without memory access
// RULE2: Context change copies level-1 out, then reloads
// RULE3: Level-1 miss fills from level-2 or memory
// RULE4: Double miss fills level-2 and level-1 together
// RULE5: Write-back writes only level-1, propagates later
// RULE6: Write-through writes level-1, level-2, memory, in order
// RULE7: Core stalls until write-through memory completes
// RULE8: Write policy defaults to write-back
// RULE9: Configuration may select write-through for later writes
// RULE10: Level-1 holds sixteen kilobytes
// RULE11: Level-2 holds at least 256 kilobytes
// RULE12: Modified lines written onward before replacement
// RULE13: One independent controller per processor
`timescale 1ns/10ps
`include "tlc_cfg.svh"
module tlc_ctrl #(
  parameter int AW = `TLC_ADDR_W,
  parameter int DW = `TLC_WORD_W,
  parameter int L1_BYTES = `TLC_L1_BYTES,
  parameter int L2_BYTES = `TLC_L2_BYTES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Processor request and answer
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [AW-1:0] cpu_addr,
  input wire logic [DW-1:0] cpu_wdata,
  output logic cpu_ready,
  output logic [DW-1:0] cpu_rdata,
  output logic init_done,
  // Context change request and completion
  input wire logic ctx_req,
  output logic ctx_done,
  // Write-through select pin from configuration
  input wire logic wt_sel,
  // System memory port
  output logic mem_req,
  output logic mem_we,
  output logic [AW-1:0] mem_addr,
  output logic [DW-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DW-1:0] mem_rdata
);
  // Geometry: one word per line, direct mapped [RULE10] [RULE11]
  localparam int N1 = L1_BYTES / `TLC_WORD_BYTES;
  localparam int N2 = L2_BYTES / `TLC_WORD_BYTES;
  localparam int I1 = $clog2(N1);
  localparam int I2 = $clog2(N2);
  localparam int T1 = AW - I1;
  localparam int T2 = AW - I2;
  localparam int E1W = 2 + T1 + DW;
  localparam int E2W = 1 + T2 + DW;

  // Address split helpers
  function automatic logic [I1-1:0] idx1(input logic [AW-1:0] a);
    return a[I1-1:0];
  endfunction
  function automatic logic [T1-1:0] tag1(input logic [AW-1:0] a);
    return a[AW-1:I1];
  endfunction
  function automatic logic [I2-1:0] idx2(input logic [AW-1:0] a);
    return a[I2-1:0];
  endfunction
  function automatic logic [T2-1:0] tag2(input logic [AW-1:0] a);
    return a[AW-1:I2];
  endfunction

  // Sequencer and latched request, private to this instance [RULE13]
  tlc_pkg::tlc_state_t state_reg, state_next;
  logic lat_we_reg, lat_we_next;
  logic [AW-1:0] lat_addr_reg, lat_addr_next;
  logic [DW-1:0] lat_wdata_reg, lat_wdata_next;
  // Sweep counter for clearing and for context flush
  logic [I2-1:0] sweep_reg, sweep_next;
  // Policy: synchroniser and applied mode
  logic pol_s1_reg, pol_s2_reg;
  logic wt_reg, wt_next;
  // Registered outputs
  logic ready_reg, ready_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic init_reg, init_next;
  logic mreq_reg, mreq_next;
  logic mwe_reg, mwe_next;
  logic [AW-1:0] maddr_reg, maddr_next;
  logic [DW-1:0] mwdata_reg, mwdata_next;
  // Array ports
  logic l1_we, l2_we;
  logic [I1-1:0] l1_wa, l1_ra;
  logic [I2-1:0] l2_wa, l2_ra;
  logic [E1W-1:0] l1_wd, l1_rd;
  logic [E2W-1:0] l2_wd, l2_rd;
  // Decoded entries
  logic l1_v, l1_d, l2_v, l1_hit, l2_hit, adv;
  logic [T1-1:0] l1_t;
  logic [DW-1:0] l1_dat;
  logic [AW-1:0] vaddr, faddr;

  // Level-1 array: valid, dirty, tag, data [RULE10]
  tlc_mem #(.DW(E1W), .AW(I1)) u_l1 (
    .mclk(mclk), .we(l1_we), .wa(l1_wa), .wd(l1_wd), .ra(l1_ra), .rd(l1_rd)
  );
  // Level-2 array: valid, tag, data [RULE11]
  tlc_mem #(.DW(E2W), .AW(I2)) u_l2 (
    .mclk(mclk), .we(l2_we), .wa(l2_wa), .wd(l2_wd), .ra(l2_ra), .rd(l2_rd)
  );

  // Entry decode and read addressing
  always_comb
  begin
    l1_v = l1_rd[E1W-1];
    l1_d = l1_rd[E1W-2];
    l1_t = l1_rd[DW+:T1];
    l1_dat = l1_rd[DW-1:0];
    l2_v = l2_rd[E2W-1];
    l1_hit = l1_v && (l1_t == tag1(lat_addr_reg));
    l2_hit = l2_v && (l2_rd[DW+:T2] == tag2(lat_addr_reg));
    vaddr = {l1_t, idx1(lat_addr_reg)};
    faddr = {l1_t, sweep_reg[I1-1:0]};
    l1_ra = (state_reg == tlc_pkg::TLC_IDLE) ? idx1(cpu_addr) : idx1(lat_addr_reg);
    l2_ra = (state_reg == tlc_pkg::TLC_IDLE) ? idx2(cpu_addr) : idx2(lat_addr_reg);
    if (state_reg == tlc_pkg::TLC_FL_RD)
    begin
      l1_ra = sweep_reg[I1-1:0];
    end
  end

  // Sequencer next-state and array write control
  always_comb
  begin
    state_next = state_reg;
    lat_we_next = lat_we_reg;
    lat_addr_next = lat_addr_reg;
    lat_wdata_next = lat_wdata_reg;
    sweep_next = sweep_reg;
    wt_next = wt_reg;
    ready_next = 1'h0;
    rdata_next = rdata_reg;
    done_next = 1'h0;
    init_next = init_reg;
    mreq_next = mreq_reg;
    mwe_next = mwe_reg;
    maddr_next = maddr_reg;
    mwdata_next = mwdata_reg;
    l1_we = 1'h0;
    l1_wa = idx1(lat_addr_reg);
    l1_wd = '0;
    l2_we = 1'h0;
    l2_wa = idx2(lat_addr_reg);
    l2_wd = '0;
    adv = 1'h0;
    unique case (state_reg)
      // Clear both arrays after reset
      tlc_pkg::TLC_INIT:
      begin
        l1_we = 1'h1;
        l1_wa = sweep_reg[I1-1:0];
        l2_we = 1'h1;
        l2_wa = sweep_reg;
        sweep_next = I2'(sweep_reg + 1'h1);
        if (&sweep_reg)
        begin
          init_next = 1'h1;
          state_next = tlc_pkg::TLC_IDLE;
        end
      end
      // Take policy, then a context change or a request
      tlc_pkg::TLC_IDLE:
      begin
        wt_next = pol_s2_reg; // [RULE9]
        if (ctx_req)
        begin
          sweep_next = '0;
          state_next = tlc_pkg::TLC_FL_RD; // [RULE2]
        end
        else if (cpu_req)
        begin
          lat_we_next = cpu_we;
          lat_addr_next = cpu_addr;
          lat_wdata_next = cpu_wdata;
          state_next = tlc_pkg::TLC_LOOK;
        end
      end
      // Level-1 lookup result
      tlc_pkg::TLC_LOOK:
      begin
        if (l1_hit)
        begin
          if (!lat_we_reg)
          begin
            rdata_next = l1_dat; // [RULE1]
            ready_next = 1'h1;
            state_next = tlc_pkg::TLC_IDLE;
          end
          else
          begin
            l1_we = 1'h1;
            l1_wd = {1'h1, !wt_reg, tag1(lat_addr_reg), lat_wdata_reg}; // [RULE5]
            if (wt_reg)
            begin
              state_next = tlc_pkg::TLC_WT_L2; // [RULE6]
            end
            else
            begin
              ready_next = 1'h1;
              state_next = tlc_pkg::TLC_IDLE;
            end
          end
        end
        else if (l1_v && l1_d)
        begin
          // Modified victim goes to level-2 and memory first [RULE12]
          l2_we = 1'h1;
          l2_wa = idx2(vaddr);
          l2_wd = {1'h1, tag2(vaddr), l1_dat};
          mreq_next = 1'h1;
          mwe_next = 1'h1;
          maddr_next = vaddr;
          mwdata_next = l1_dat;
          state_next = tlc_pkg::TLC_EVICT;
        end
        else
        begin
          state_next = tlc_pkg::TLC_L2CHK; // [RULE3]
        end
      end
      // Wait for victim write to memory
      tlc_pkg::TLC_EVICT:
      begin
        if (mem_ack)
        begin
          mreq_next = 1'h0;
          state_next = tlc_pkg::TLC_RD_L2;
        end
      end
      // Re-read level-2 after it was written
      tlc_pkg::TLC_RD_L2:
      begin
        state_next = tlc_pkg::TLC_L2CHK;
      end
      // Level-2 lookup result
      tlc_pkg::TLC_L2CHK:
      begin
        if (l2_hit)
        begin
          l1_we = 1'h1;
          l1_wd = {2'h2, tag1(lat_addr_reg), l2_rd[DW-1:0]}; // [RULE3]
          state_next = tlc_pkg::TLC_RD_L1;
        end
        else
        begin
          mreq_next = 1'h1;
          mwe_next = 1'h0;
          maddr_next = lat_addr_reg;
          state_next = tlc_pkg::TLC_MEM_RD;
        end
      end
      // Memory read fills both levels at once
      tlc_pkg::TLC_MEM_RD:
      begin
        if (mem_ack)
        begin
          mreq_next = 1'h0;
          l1_we = 1'h1;
          l1_wd = {2'h2, tag1(lat_addr_reg), mem_rdata}; // [RULE4]
          l2_we = 1'h1;
          l2_wd = {1'h1, tag2(lat_addr_reg), mem_rdata}; // [RULE4]
          state_next = tlc_pkg::TLC_RD_L1;
        end
      end
      // Re-read level-1, then retry the request as a hit
      tlc_pkg::TLC_RD_L1:
      begin
        state_next = tlc_pkg::TLC_LOOK;
      end
      // Write-through: level-2 after level-1
      tlc_pkg::TLC_WT_L2:
      begin
        l2_we = 1'h1;
        l2_wd = {1'h1, tag2(lat_addr_reg), lat_wdata_reg}; // [RULE6]
        mreq_next = 1'h1;
        mwe_next = 1'h1;
        maddr_next = lat_addr_reg;
        mwdata_next = lat_wdata_reg;
        state_next = tlc_pkg::TLC_WT_MEM;
      end
      // Write-through: core held until memory answers
      tlc_pkg::TLC_WT_MEM:
      begin
        if (mem_ack)
        begin
          mreq_next = 1'h0;
          ready_next = 1'h1; // [RULE7]
          state_next = tlc_pkg::TLC_IDLE;
        end
      end
      // Flush: read one level-1 entry
      tlc_pkg::TLC_FL_RD:
      begin
        state_next = tlc_pkg::TLC_FL_CHK;
      end
      // Flush: copy entry to level-2 and drop it from level-1
      tlc_pkg::TLC_FL_CHK:
      begin
        adv = 1'h1;
        if (l1_v)
        begin
          l2_we = 1'h1;
          l2_wa = idx2(faddr);
          l2_wd = {1'h1, tag2(faddr), l1_dat}; // [RULE2]
          l1_we = 1'h1;
          l1_wa = sweep_reg[I1-1:0];
          if (l1_d)
          begin
            adv = 1'h0;
            mreq_next = 1'h1; // [RULE12]
            mwe_next = 1'h1;
            maddr_next = faddr;
            mwdata_next = l1_dat;
            state_next = tlc_pkg::TLC_FL_MEM;
          end
        end
      end
      // Flush: wait for modified entry to reach memory
      tlc_pkg::TLC_FL_MEM:
      begin
        if (mem_ack)
        begin
          mreq_next = 1'h0;
          adv = 1'h1;
        end
      end
    endcase
    // Step the flush or finish it
    if (adv)
    begin
      sweep_next = I2'(sweep_reg + 1'h1);
      state_next = tlc_pkg::TLC_FL_RD;
      if (&sweep_reg[I1-1:0])
      begin
        done_next = 1'h1;
        state_next = tlc_pkg::TLC_IDLE;
      end
    end
  end

  // Register all sequencer state
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= tlc_pkg::TLC_INIT;
      lat_we_reg <= 1'h0;
      lat_addr_reg <= '0;
      lat_wdata_reg <= '0;
      sweep_reg <= '0;
      pol_s1_reg <= `TLC_POLICY_RESET;
      pol_s2_reg <= `TLC_POLICY_RESET;
      wt_reg <= `TLC_POLICY_RESET; // [RULE8]
      ready_reg <= 1'h0;
      rdata_reg <= '0;
      done_reg <= 1'h0;
      init_reg <= 1'h0;
      mreq_reg <= 1'h0;
      mwe_reg <= 1'h0;
      maddr_reg <= '0;
      mwdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      lat_we_reg <= lat_we_next;
      lat_addr_reg <= lat_addr_next;
      lat_wdata_reg <= lat_wdata_next;
      sweep_reg <= sweep_next;
      pol_s1_reg <= wt_sel;
      pol_s2_reg <= pol_s1_reg;
      wt_reg <= wt_next;
      ready_reg <= ready_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      init_reg <= init_next;
      mreq_reg <= mreq_next;
      mwe_reg <= mwe_next;
      maddr_reg <= maddr_next;
      mwdata_reg <= mwdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign cpu_ready = ready_reg;
  assign cpu_rdata = rdata_reg;
  assign ctx_done = done_reg;
  assign init_done = init_reg;
  assign mem_req = mreq_reg;
  assign mem_we = mwe_reg;
  assign mem_addr = maddr_reg;
  assign mem_wdata = mwdata_reg;

  // Checks on the sequencer
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Write-through write hits go onward on purpose; every other hit stays local
  property p_hit_local;
    (state_reg == tlc_pkg::TLC_LOOK) && l1_hit && !(lat_we_reg && wt_reg)
      |=> !mreq_reg ##1 !mreq_reg;
  endproperty
  a_hit_local: assert property (p_hit_local) else $error("hit started memory"); // [RULE1]

  property p_wb_write;
    (state_reg == tlc_pkg::TLC_LOOK) && l1_hit && lat_we_reg && !wt_reg
      |-> l1_we && l1_wd[E1W-2] ##1 ready_reg && !mreq_reg;
  endproperty
  a_wb_write: assert property (p_wb_write) else $error("write-back write wrong"); // [RULE5]

  property p_wt_order;
    (state_reg == tlc_pkg::TLC_LOOK) && l1_hit && lat_we_reg && wt_reg
      |-> l1_we ##1 l2_we && !mreq_reg ##1 mreq_reg && mwe_reg;
  endproperty
  a_wt_order: assert property (p_wt_order) else $error("write-through order wrong"); // [RULE6]

  property p_wt_stall;
    (state_reg == tlc_pkg::TLC_WT_MEM) && !mem_ack |=> !ready_reg;
  endproperty
  a_wt_stall: assert property (p_wt_stall) else $error("core released early"); // [RULE7]

  property p_fill_both;
    (state_reg == tlc_pkg::TLC_MEM_RD) && mem_ack |-> l1_we && l2_we ##1 !mreq_reg;
  endproperty
  a_fill_both: assert property (p_fill_both) else $error("double miss fill wrong"); // [RULE4]

  property p_l2_fill;
    (state_reg == tlc_pkg::TLC_L2CHK) && l2_hit |-> l1_we ##1 !mreq_reg ##1 l1_hit;
  endproperty
  a_l2_fill: assert property (p_l2_fill) else $error("level-2 fill wrong"); // [RULE3]

  property p_evict;
    (state_reg == tlc_pkg::TLC_LOOK) && !l1_hit && l1_v && l1_d
      |-> l2_we ##1 mreq_reg && mwe_reg && (maddr_reg == $past(vaddr));
  endproperty
  a_evict: assert property (p_evict) else $error("modified victim lost"); // [RULE12]

  property p_flush_copy;
    (state_reg == tlc_pkg::TLC_FL_CHK) && l1_v |-> l2_we && l1_we && (l1_wd == '0);
  endproperty
  a_flush_copy: assert property (p_flush_copy) else $error("flush copy wrong"); // [RULE2]

  property p_policy_reset;
    $rose(init_reg) |-> !wt_reg;
  endproperty
  a_policy_reset: assert property (p_policy_reset) else $error("policy not write-back"); // [RULE8]
endmodule

// File: core/tlc_mem.sv
// Simple dual-port array with registered read data
`timescale 1ns/10ps
module tlc_mem #(
  parameter int DW = 32,
  parameter int AW = 8
) (
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [DW-1:0] wd,
  // Read port
  input wire logic [AW-1:0] ra,
  output logic [DW-1:0] rd
);
  // Storage, not reset; the controller clears it after reset
  logic [DW-1:0] mem_arr [0:(1<<AW)-1];
  // Read data register
  logic [DW-1:0] rd_reg;

  // Write when enabled, registered read every edge
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem_arr[wa] <= wd;
    end
    rd_reg <= mem_arr[ra];
  end

  assign rd = rd_reg;
endmodule

// File: core/tlc_pkg.sv
// Types shared by the two-level cache controller
package tlc_pkg;
  // Controller sequencer states, one-hot
  typedef enum logic [12:0] {
    TLC_INIT   = 13'h0001,
    TLC_IDLE   = 13'h0002,
    TLC_LOOK   = 13'h0004,
    TLC_EVICT  = 13'h0008,
    TLC_RD_L2  = 13'h0010,
    TLC_L2CHK  = 13'h0020,
    TLC_MEM_RD = 13'h0040,
    TLC_RD_L1  = 13'h0080,
    TLC_WT_L2  = 13'h0100,
    TLC_WT_MEM = 13'h0200,
    TLC_FL_RD  = 13'h0400,
    TLC_FL_CHK = 13'h0800,
    TLC_FL_MEM = 13'h1000
  } tlc_state_t;
endpackage

// File: sim/testbench.sv
// Self-checking bench for the two-level cache controller
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  // Controller stimulus and observation
  logic mclk, nrst, cpu_req, cpu_we, cpu_ready, init_done, ctx_req, ctx_done, wt_sel;
  logic [29:0] cpu_addr, mem_addr;
  logic [31:0] cpu_wdata, cpu_rdata, mem_wdata, mem_rdata, q;
  logic mem_req, mem_we, mem_ack;
  logic [3:0] wait_cyc;
  // Bookkeeping
  int miscompares = 0;
  int n_compared = 0;
  int n_rd = 0;
  int n_wr = 0;
  int dr, dw, ncyc;

  // Small arrays: 4 level-1 entries, 16 level-2 entries
  tlc_ctrl #(.L1_BYTES(16), .L2_BYTES(64)) u_tlc_ctrl (.mclk(mclk), .nrst(nrst),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .init_done(init_done),
    .ctx_req(ctx_req), .ctx_done(ctx_done), .wt_sel(wt_sel), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  // Far-side memory
  tlc_mem_model u_tlc_mem_model (.mclk(mclk), .nrst(nrst), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .wait_cyc(wait_cyc));

  // Clock at 50 ns period
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  // Count finished memory accesses by kind
  always @(posedge mclk)
  begin
    if (mem_req && mem_ack && mem_we)
      n_wr++;
    else if (mem_req && mem_ack)
      n_rd++;
  end

  // Unwritten memory content
  function automatic logic [31:0] pat(input logic [29:0] a);
    return {2'h0, a} ^ 32'h5A5A_0000;
  endfunction

  // Verdict and end of run
  task final_report;
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One processor request; records memory traffic and wait
  task automatic cpu_op(input logic we, input logic [29:0] a, input logic [31:0] d);
    int r0;
    int w0;
    r0 = n_rd;
    w0 = n_wr;
    @(negedge mclk);
    cpu_req = 1'h1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge mclk);
    cpu_req = 1'h0;
    for (ncyc = 0; ncyc < 300 && cpu_ready !== 1'h1; ncyc++)
      @(negedge mclk);
    if (ncyc == 300)
    begin
      miscompares++;
      final_report();
    end
    q = cpu_rdata;
    dr = n_rd - r0;
    dw = n_wr - w0;
  endtask

  // Reset release and array clearing
  task t_init;
    int i;
    for (i = 0; i < 100 && init_done !== 1'h1; i++)
      @(negedge mclk);
    `CHK(init_done, 1'h1)
  endtask

  // Miss from memory, then a local hit
  task t_hit;
    cpu_op(1'h0, 30'h05, 32'h0);
    `CHK(q, pat(30'h05))
    `CHK(dr, 1)
    cpu_op(1'h0, 30'h05, 32'h0);
    `CHK(q, pat(30'h05))
    `CHK(dr + dw, 0)
  endtask

  // Double miss fills level-2 as well
  task t_both;
    cpu_op(1'h0, 30'h01, 32'h0);
    `CHK(dr, 1)
    cpu_op(1'h0, 30'h05, 32'h0);
    `CHK(q, pat(30'h05))
    `CHK(dr, 0)
    cpu_op(1'h0, 30'h01, 32'h0);
    `CHK(q, pat(30'h01))
    `CHK(dr, 0)
  endtask

  // Default write-back, then eviction of the modified word
  task t_wb;
    cpu_op(1'h1, 30'h01, 32'hC0DE_0001);
    `CHK(dr + dw, 0)
    cpu_op(1'h0, 30'h01, 32'h0);
    `CHK(q, 32'hC0DE_0001)
    `CHK(u_tlc_mem_model.peek(30'h01), pat(30'h01))
    cpu_op(1'h0, 30'h05, 32'h0);
    `CHK(dw, 1)
    `CHK(u_tlc_mem_model.peek(30'h01), 32'hC0DE_0001)
    cpu_op(1'h0, 30'h01, 32'h0);
    `CHK(q, 32'hC0DE_0001)
    `CHK(dr, 0)
  endtask

  // Context change copies level-1 out before reloading
  task t_ctx;
    int i;
    cpu_op(1'h1, 30'h02, 32'hC0DE_0002);
    @(negedge mclk);
    ctx_req = 1'h1;
    @(negedge mclk);
    ctx_req = 1'h0;
    for (i = 0; i < 500 && ctx_done !== 1'h1; i++)
      @(negedge mclk);
    `CHK(ctx_done, 1'h1)
    `CHK(u_tlc_mem_model.peek(30'h02), 32'hC0DE_0002)
    cpu_op(1'h0, 30'h02, 32'h0);
    `CHK(q, 32'hC0DE_0002)
    `CHK(dr, 0)
  endtask

  // Policy pin and memory speed, then time for the pin to reach the policy
  task set_policy(input logic wt, input logic [3:0] w);
    wt_sel = wt;
    wait_cyc = w;
    repeat (4) @(negedge mclk);
  endtask

  // Write-through selected, slow memory, then back to write-back
  task t_wt;
    set_policy(1'h1, 4'h6);
    cpu_op(1'h0, 30'h03, 32'h0);
    cpu_op(1'h1, 30'h03, 32'hC0DE_0003);
    `CHK(dw, 1)
    `CHK(u_tlc_mem_model.peek(30'h03), 32'hC0DE_0003)
    `CHK(ncyc > 6, 1'h1)
    cpu_op(1'h1, 30'h03, 32'hC0DE_0004);
    `CHK(dw, 1)
    cpu_op(1'h0, 30'h03, 32'h0);
    `CHK(q, 32'hC0DE_0004)
    `CHK(dr + dw, 0)
    set_policy(1'h0, 4'h0);
    cpu_op(1'h1, 30'h03, 32'hC0DE_0005);
    `CHK(dw, 0)
  endtask

  // Main sequence
  initial
  begin
    nrst = 1'h0;
    cpu_req = 1'h0;
    cpu_we = 1'h0;
    cpu_addr = 30'h0;
    cpu_wdata = 32'h0;
    ctx_req = 1'h0;
    wt_sel = 1'h0;
    wait_cyc = 4'h0;
    repeat (4) @(negedge mclk);
    nrst = 1'h1;
    t_init();
    t_hit();
    t_both();
    t_wb();
    t_ctx();
    t_wt();
    final_report();
  end
endmodule

// File: sim/tlc_mem_model.sv
// Behavioural system memory facing the controller's memory port
`timescale 1ns/10ps
module tlc_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Request from the controller
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [29:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  // Answer
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Extra wait cycles before each answer
  input wire logic [3:0] wait_cyc
);
  // Words written so far; others read as an address pattern
  logic [31:0] store [logic [29:0]];
  // Wait counter for the access in flight
  logic [3:0] cnt;
  // Last word read out
  logic [31:0] last;

  // Current content of one word
  function automatic logic [31:0] peek(input logic [29:0] a);
    if (store.exists(a))
      return store[a];
    return {2'h0, a} ^ 32'h5A5A_0000;
  endfunction

  // One answer pulse after the chosen wait, then a rest cycle
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_ack <= 1'h0;
      cnt <= 4'h0;
      last <= 32'h0;
    end
    else if (mem_ack)
      mem_ack <= 1'h0;
    else if (mem_req && cnt < wait_cyc)
      cnt <= cnt + 4'h1;
    else if (mem_req)
    begin
      mem_ack <= 1'h1;
      cnt <= 4'h0;
      // Write data is stable until the answer edge
      if (mem_we)
        store[mem_addr] = mem_wdata;
      else
        last <= peek(mem_addr);
    end
  end

  // Data is only meaningful in the answer cycle; inverted otherwise
  assign mem_rdata = mem_ack ? last : ~last;
endmodule
